/* File: logic/input_sync.sv */
// two-flop synchroniser, one chain per bit
`timescale 1ns/100ps
module input_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta;

  // ----------------------------------------------------------------
  // per-bit chains
  // ----------------------------------------------------------------
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          meta[i]     <= 1'b0;
          sync_out[i] <= 1'b0;
        end else begin
          meta[i]     <= async_in[i];
          sync_out[i] <= meta[i];
        end
      end
    end
  endgenerate

endmodule : input_sync

/* File: logic/loader_cfg.svh */
// offsets, field positions, reset values and timing counts of the parallel loader
`ifndef LOADER_CFG_SVH
`define LOADER_CFG_SVH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define REG_CTRL        12'h000
`define REG_IMAGE_WORDS 12'h004
`define REG_STATUS      12'h008
`define REG_WORD_COUNT  12'h00c
`define REG_LAST_WORD   12'h010
`define REG_INT_STAT    12'h014
`define REG_INT_MASK    12'h018
`define REG_USER_OUT    12'h01c
`define REG_USER_OE     12'h020
`define REG_USER_IN     12'h024

// ----------------------------------------------------------------
// fields and reset values
// ----------------------------------------------------------------
`define CTRL_WIDE16_BIT     0
`define CTRL_RST            1'h1
`define IMAGE_WORDS_RST     32'h0000_0010
`define OPT_INIT_DONE_BIT   0
`define INT_LOAD_DONE_BIT   0
`define INT_USER_MODE_BIT   1
`define INT_RECONFIG_BIT    2
`define INT_BITS            3
`define INIT_FALL_EDGES     2'h2

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define PCLK_PERIOD_NS      25
`define POR_DELAY_NS        100000
`define POR_DELAY_CYC       ((`POR_DELAY_NS + `PCLK_PERIOD_NS - 1) / `PCLK_PERIOD_NS)
`define POR_CNT_W           13

`endif

/* File: logic/loader_pkg.sv */
// types shared by the parallel loader
package loader_pkg;

  // ----------------------------------------------------------------
  // loader sequence states
  // ----------------------------------------------------------------
  typedef enum logic [4:0] {
    st_por   = 5'b00001,
    st_clear = 5'b00010,
    st_load  = 5'b00100,
    st_init  = 5'b01000,
    st_user  = 5'b10000
  } loader_state_e;

endpackage : loader_pkg

/* File: logic/parallel_config_loader.sv */
// device-side parallel configuration loader with apb register file
//
// Behaviour
// - user mode shows all lines high; request low starts a reconfiguration
// - readiness output held low for the whole power-on delay
// - load complete stays low after power-up, before and during transfer
// - configuration clock ignored once configuration completes; host keeps driving it
// - sixteen-bit mode uses bits 15..0, eight-bit mode bits 7..0
// - after configuration data bits 31..0 become user input/output
// - load complete goes high only after the whole image is received
// - two falling clock edges after completion run initialization into user mode
// - when option bit loaded, init-done pin driven low until initialization ends
// - one data word taken per configuration clock cycle
//
// Our own choices: the register offsets and register access over APB.
`timescale 1ns/100ps
`include "loader_cfg.svh"
module parallel_config_loader
  import loader_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic [11:0] paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             irq,
  input  wire logic        reconfig_request_n,
  input  wire logic        config_clock,
  input  wire logic [31:0] data_in,
  output logic      [31:0] data_out,
  output logic      [31:0] data_oe_n,
  output logic             config_ready_n,
  output logic             load_complete,
  output logic             init_done_out,
  output logic             init_done_oe_n
);

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  loader_state_e         state;
  loader_state_e         next_state;
  logic                  por_done;
  logic [33:0]           pins_sync;
  logic                  req_n_s;
  logic                  clk_s;
  logic                  clk_prev;
  logic                  clk_rise;
  logic                  clk_fall;
  logic [31:0]           data_s;
  logic [31:0]           word_in;
  logic                  wide16;
  logic [31:0]           image_words;
  logic [31:0]           word_count;
  logic [31:0]           last_word;
  logic                  init_pin_en;
  logic [1:0]            fall_count;
  logic [`INT_BITS-1:0]  int_stat;
  logic [`INT_BITS-1:0]  int_mask;
  logic [`INT_BITS-1:0]  events;
  logic [`INT_BITS-1:0]  int_clear;
  logic [31:0]           user_out;
  logic [31:0]           user_oe;
  logic                  access;
  logic                  wr_fire;
  logic                  addr_hit;
  logic [31:0]           rd_value;
  logic                  last_word_in;

  // ----------------------------------------------------------------
  // pin synchronisers and power-on delay
  // ----------------------------------------------------------------
  input_sync #(
    .WIDTH (34)
  ) u_sync (
    .pclk     (pclk),
    .presetn  (presetn),
    .async_in ({reconfig_request_n, config_clock, data_in}),
    .sync_out (pins_sync)
  );

  por_delay u_por (
    .pclk     (pclk),
    .presetn  (presetn),
    .por_done (por_done)
  );

  assign req_n_s = pins_sync[33];
  assign clk_s   = pins_sync[32];
  assign data_s  = pins_sync[31:0];

  // ----------------------------------------------------------------
  // configuration clock edges
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clk_prev <= 1'b0;
    end else begin
      clk_prev <= clk_s;
    end
  end

  assign clk_rise = clk_s & ~clk_prev;
  assign clk_fall = ~clk_s & clk_prev;

  // data sampled through the same two flops as the clock, so they stay aligned
  assign word_in = wide16 ? {16'h0000, data_s[15:0]} : {24'h000000, data_s[7:0]};

  assign last_word_in = (word_count + 32'h0000_0001) >= image_words;

  // ----------------------------------------------------------------
  // sequence state
  // ----------------------------------------------------------------
  always_comb begin
    next_state = state;
    unique case (state)
      st_por: begin
        if (por_done) begin
          next_state = req_n_s ? st_load : st_clear;
        end
      end
      st_clear: begin
        if (req_n_s) begin
          next_state = st_load;
        end
      end
      st_load: begin
        if (!req_n_s) begin
          next_state = st_clear;
        end else if (clk_rise && last_word_in) begin
          next_state = st_init;
        end
      end
      st_init: begin
        if (!req_n_s) begin
          next_state = st_clear;
        // the first fall in init closes the last word's clock cycle, so the exit waits for the third fall in init
        end else if (clk_fall && fall_count == `INIT_FALL_EDGES) begin
          next_state = st_user;
        end
      end
      st_user: begin
        if (!req_n_s) begin
          next_state = st_clear;
        end
      end
      default: begin
        next_state = st_por;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= st_por;
    end else begin
      state <= next_state;
    end
  end

  // ----------------------------------------------------------------
  // word capture and counting
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      word_count  <= 32'h0000_0000;
      last_word   <= 32'h0000_0000;
      init_pin_en <= 1'b0;
    end else if (state == st_clear) begin
      word_count  <= 32'h0000_0000;
      init_pin_en <= 1'b0;
    end else if (state == st_load && req_n_s && clk_rise) begin
      word_count <= word_count + 32'h0000_0001;
      last_word  <= word_in;
      if (word_count == 32'h0000_0000) begin
        init_pin_en <= word_in[`OPT_INIT_DONE_BIT];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fall_count <= 2'h0;
    end else if (state != st_init) begin
      fall_count <= 2'h0;
    end else if (clk_fall) begin
      fall_count <= fall_count + 2'h1;
    end
  end

  // ----------------------------------------------------------------
  // pin outputs
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      config_ready_n <= 1'b0;
      load_complete  <= 1'b0;
    end else begin
      config_ready_n <= (next_state != st_por) && (next_state != st_clear);
      load_complete  <= (next_state == st_init) || (next_state == st_user);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      init_done_out  <= 1'b0;
      init_done_oe_n <= 1'b1;
    end else begin
      init_done_out  <= 1'b0;
      // pin drives low only while enabled and not yet in user mode
      init_done_oe_n <= ~(init_pin_en && next_state != st_user);
    end
  end

  // user pins stay released until user mode
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      data_out  <= 32'h0000_0000;
      data_oe_n <= 32'hffff_ffff;
    end else begin
      data_out  <= user_out;
      data_oe_n <= (next_state == st_user) ? ~user_oe : 32'hffff_ffff;
    end
  end

  // ----------------------------------------------------------------
  // interrupts
  // ----------------------------------------------------------------
  assign events[`INT_LOAD_DONE_BIT] = (state == st_load) && (next_state == st_init);
  assign events[`INT_USER_MODE_BIT] = (state == st_init) && (next_state == st_user);
  assign events[`INT_RECONFIG_BIT]  = (state != st_clear) && (next_state == st_clear)
                                      && (state != st_por);

  assign int_clear = (wr_fire && paddr == `REG_INT_STAT) ? pwdata[`INT_BITS-1:0]
                                                          : {`INT_BITS{1'b0}};

  // a new event wins over a clear in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      int_stat <= {`INT_BITS{1'b0}};
    end else begin
      int_stat <= (int_stat & ~int_clear) | events;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(((int_stat & ~int_clear) | events) & int_mask);
    end
  end

  // ----------------------------------------------------------------
  // apb slave
  // ----------------------------------------------------------------
  assign access  = psel & penable & ~pready;
  assign wr_fire = psel & penable & pready & pwrite;

  always_comb begin
    addr_hit = 1'b1;
    rd_value = 32'h0000_0000;
    unique case (paddr)
      `REG_CTRL:        rd_value = {31'h0, wide16};
      `REG_IMAGE_WORDS: rd_value = image_words;
      `REG_STATUS:      rd_value = {24'h0, init_pin_en, req_n_s, state, 1'b0};
      `REG_WORD_COUNT:  rd_value = word_count;
      `REG_LAST_WORD:   rd_value = last_word;
      `REG_INT_STAT:    rd_value = {29'h0, int_stat};
      `REG_INT_MASK:    rd_value = {29'h0, int_mask};
      `REG_USER_OUT:    rd_value = user_out;
      `REG_USER_OE:     rd_value = user_oe;
      `REG_USER_IN:     rd_value = data_s;
      default:          addr_hit = 1'b0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= access;
      pslverr <= access & ~addr_hit;
      if (access && !pwrite) begin
        prdata <= addr_hit ? rd_value : 32'h0000_0000;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wide16      <= `CTRL_RST;
      image_words <= `IMAGE_WORDS_RST;
      int_mask    <= {`INT_BITS{1'b0}};
      user_out    <= 32'h0000_0000;
      user_oe     <= 32'h0000_0000;
    end else if (wr_fire) begin
      unique case (paddr)
        `REG_CTRL:        wide16      <= pwdata[`CTRL_WIDE16_BIT];
        `REG_IMAGE_WORDS: image_words <= pwdata;
        `REG_INT_MASK:    int_mask    <= pwdata[`INT_BITS-1:0];
        `REG_USER_OUT:    user_out    <= pwdata;
        `REG_USER_OE:     user_oe     <= pwdata;
        default:          ;
      endcase
    end
  end

endmodule : parallel_config_loader

/* File: logic/por_delay.sv */
// power-on delay counter
`timescale 1ns/100ps
`include "loader_cfg.svh"
module por_delay (
  input  wire logic pclk,
  input  wire logic presetn,
  output logic      por_done
);

  logic [`POR_CNT_W-1:0] count;

  // ----------------------------------------------------------------
  // count once after reset, then hold
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count    <= '0;
      por_done <= 1'b0;
    end else if (!por_done) begin
      count <= count + `POR_CNT_W'(1);
      if (count == `POR_CNT_W'(`POR_DELAY_CYC - 1)) begin
        por_done <= 1'b1;
      end
    end
  end

endmodule : por_delay

/* File: verification/config_host_model.sv */
// behavioural configuration host on the loader pins
`timescale 1ns/100ps
module config_host_model (
  input  logic        pclk,
  output logic        reconfig_request_n,
  output logic        config_clock,
  output logic [31:0] data_in
);
  initial begin
    reconfig_request_n = 1'b1;
    config_clock = 1'b0;
    data_in = 32'h0;
  end
  // pins change just after a pclk rising edge; eight pclk cycles make one link cycle
  task restart();
    reconfig_request_n <= 1'b0;
    repeat (12) @(posedge pclk);
    reconfig_request_n <= 1'b1;
    repeat (12) @(posedge pclk);
  endtask : restart
  task word(input logic [31:0] w);
    data_in <= w;
    repeat (4) @(posedge pclk);
    config_clock <= 1'b1;
    repeat (2) @(posedge pclk);
    // hold spent: show something other than the word
    data_in <= ~w;
    repeat (2) @(posedge pclk);
    config_clock <= 1'b0;
  endtask : word
  task fall_edges(input int n);
    repeat (n) begin
      repeat (4) @(posedge pclk);
      config_clock <= 1'b1;
      repeat (4) @(posedge pclk);
      config_clock <= 1'b0;
    end
  endtask : fall_edges
endmodule : config_host_model

/* File: verification/parallel_config_loader_properties.sv */
// port assertions for the parallel loader
`timescale 1ns/100ps
`include "loader_cfg.svh"
module loader_checker (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        config_ready_n,
  input wire logic        load_complete,
  input wire logic [31:0] data_oe_n,
  input wire logic        init_done_oe_n
);
  logic [12:0] por_cnt;
  // cycles since reset release, saturating
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) por_cnt <= 13'h0;
    else if (por_cnt != 13'h1fff) por_cnt <= por_cnt + 13'h1;
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_ready_por_hold: assert property (por_cnt < `POR_DELAY_CYC - 2 |-> !config_ready_n)
    else $error("ready released during power-on delay");
  a_done_por_low: assert property (por_cnt < `POR_DELAY_CYC |-> !load_complete)
    else $error("load complete high during power-on delay");
  a_done_needs_ready: assert property ($rose(load_complete) |-> config_ready_n)
    else $error("load complete rose without readiness");
  a_done_kept: assert property ($fell(load_complete) |-> ##[0:3] !config_ready_n)
    else $error("load complete fell without a request");
  a_ready_entry: assert property ($rose(config_ready_n) |-> !load_complete)
    else $error("new load entered with load complete high");
  a_pins_released: assert property (!load_complete ##1 !load_complete |-> &data_oe_n)
    else $error("data pins driven outside user mode");
  a_init_fall: assert property ($fell(init_done_oe_n) |-> !load_complete)
    else $error("init pin pulled low after completion");
  a_apb_wait: assert property (psel && penable && !pready |=> pready)
    else $error("apb answer not after one wait state");
  a_err_pulse: assert property (pslverr |-> pready ##1 !pslverr)
    else $error("slave error not a single pulse with ready");
  c_done: cover property ($rose(load_complete));
  c_user: cover property ($rose(init_done_oe_n));
  c_err: cover property (pslverr);
endmodule : loader_checker
bind parallel_config_loader loader_checker chk_u (.pclk, .presetn, .psel, .penable, .pready,
  .pslverr, .config_ready_n, .load_complete, .data_oe_n, .init_done_oe_n);

/* File: verification/test_parallel_config_loader.sv */
// self-checking bench for the parallel loader
`timescale 1ns/100ps
`include "loader_cfg.svh"
module test_parallel_config_loader;
  logic        pclk, presetn, psel, penable, pwrite, rerr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, data_out, data_oe_n, data_in, rdv;
  logic        pready, pslverr, irq, reconfig_request_n, config_clock;
  logic        config_ready_n, load_complete, init_done_out, init_done_oe_n;
  int          err_total = 0, num_checks = 0;
  always #12.5 pclk = ~pclk;
  parallel_config_loader dut_u (.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata,
    .prdata, .pready, .pslverr, .irq, .reconfig_request_n, .config_clock, .data_in,
    .data_out, .data_oe_n, .config_ready_n, .load_complete, .init_done_out, .init_done_oe_n);
  config_host_model host_u (.pclk, .reconfig_request_n, .config_clock, .data_in);
  task chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // wait for the answer; only the watchdog ends a hung transfer
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rdv = prdata;
    rerr = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask : apb
  task rd(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rdv, e);
  endtask : rd
  task settle();
    repeat (8) @(posedge pclk);
  endtask : settle
  task t_por();
    repeat (3990) @(posedge pclk);
    chk(config_ready_n, 1'b0);
    chk(load_complete, 1'b0);
    repeat (20) @(posedge pclk);
    chk(config_ready_n, 1'b1);
  endtask : t_por
  task t_regs();
    rd(`REG_CTRL, 32'h1);
    rd(`REG_IMAGE_WORDS, 32'h10);
    rd(`REG_INT_MASK, 32'h0);
    rd(12'h100, 32'h0);
    chk(rerr, 1'b1);
    apb(1'b1, `REG_WORD_COUNT, 32'h5);
    rd(`REG_WORD_COUNT, 32'h0);
  endtask : t_regs
  task t_load16();
    apb(1'b1, `REG_IMAGE_WORDS, 32'h3);
    apb(1'b1, `REG_INT_MASK, 32'h7);
    host_u.restart();
    apb(1'b1, `REG_INT_STAT, 32'h7);
    host_u.word(32'hffff_0001);
    host_u.word(32'hdead_1234);
    settle();
    chk(load_complete, 1'b0);
    chk(init_done_oe_n, 1'b0);
    chk(init_done_out, 1'b0);
    rd(`REG_WORD_COUNT, 32'h2);
    host_u.word(32'hbeef_5678);
    settle();
    chk(load_complete, 1'b1);
    chk(irq, 1'b1);
    rd(`REG_LAST_WORD, 32'h5678);
    rd(`REG_INT_STAT, 32'h1);
    host_u.fall_edges(1);
    settle();
    rd(`REG_STATUS, 32'hd0);
    chk(init_done_oe_n, 1'b0);
    host_u.fall_edges(1);
    settle();
    rd(`REG_STATUS, 32'he0);
    chk(init_done_oe_n, 1'b1);
    host_u.word(32'h0000_7777);
    settle();
    rd(`REG_WORD_COUNT, 32'h3);
    chk(load_complete, 1'b1);
    apb(1'b1, `REG_USER_OE, 32'hff);
    apb(1'b1, `REG_USER_OUT, 32'ha5);
    settle();
    chk(data_oe_n, 32'hffff_ff00);
    chk(data_out, 32'ha5);
    rd(`REG_USER_IN, 32'hffff_8888);
    apb(1'b1, `REG_INT_MASK, 32'h0);
    settle();
    chk(irq, 1'b0);
    rd(`REG_INT_STAT, 32'h3);
    apb(1'b1, `REG_INT_STAT, 32'h3);
    rd(`REG_INT_STAT, 32'h0);
  endtask : t_load16
  task t_load8();
    apb(1'b1, `REG_CTRL, 32'h0);
    apb(1'b1, `REG_IMAGE_WORDS, 32'h2);
    fork
      host_u.restart();
      begin
        repeat (8) @(posedge pclk);
        chk(config_ready_n, 1'b0);
        chk(load_complete, 1'b0);
      end
    join
    host_u.word(32'h1234_56ff);
    host_u.restart();
    host_u.word(32'h0000_ab98);
    settle();
    chk(load_complete, 1'b0);
    chk(init_done_oe_n, 1'b1);
    host_u.word(32'h5555_aa66);
    settle();
    chk(load_complete, 1'b1);
    rd(`REG_LAST_WORD, 32'h66);
    host_u.fall_edges(2);
    settle();
    chk(data_oe_n, 32'hffff_ff00);
    rd(`REG_INT_STAT, 32'h7);
  endtask : t_load8
  task complete_run();
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : complete_run
  initial begin
    pclk = 1'b0;
    presetn <= 1'b0;
    psel <= 1'b0;
    penable <= 1'b0;
    pwrite <= 1'b0;
    paddr <= 12'h000;
    pwdata <= 32'h0000_0000;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    t_por();
    t_regs();
    t_load16();
    t_load8();
    complete_run();
  end
  initial begin
    #500000;
    err_total++;
    complete_run();
  end
endmodule : test_parallel_config_loader
